// ### blank_timer.sv
// down counter that blanks the short detector after each pump start
`timescale 1ns/1ps
module blank_timer
  import fault_protect_pkg::*;
#(
  parameter int CYCLES = SHORT_BLANK_CYCLES
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // control
  input wire logic start,
  input wire logic abort,
  // status
  output logic done
);

  logic [31:0] count_r;
  logic [31:0] count_nxt;
  logic running_r;
  logic running_nxt;
  logic last;

  assign last = running_r && (count_r == 32'h0000_0001);
  assign running_nxt = start ? 1'b1 : ((abort || last) ? 1'b0 : running_r);
  assign count_nxt = start ? 32'(CYCLES) : (running_r ? count_r - 32'h0000_0001 : count_r);
  // done looks at registers only: the caller's next state feeds start and abort, so gating here would loop
  assign done = last;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count_r <= 32'h0000_0000;
      running_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      running_r <= running_nxt;
    end
  end

endmodule : blank_timer

// ### fault_protect_host.sv
// host model: register transfers, active mode writes and the pulled-up interrupt line
`timescale 1ns/1ps
module fault_protect_host (
  // clock
  input wire logic mclk,
  // register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // active mode writes
  output logic active_mode_set,
  output logic active_mode_clr,
  // interrupt pin
  input wire logic irq_pin_n_out,
  input wire logic irq_pin_n_oe,
  output logic irq_n
);
  assign irq_n = irq_pin_n_oe ? irq_pin_n_out : 1'b1;
  initial {reg_addr, reg_wr, reg_wdata, reg_rd, active_mode_set, active_mode_clr} = '0;

  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge mclk);
    {reg_wr, reg_rd} <= 2'h0;
    // idle lines show inverted data so a stale value cannot pass
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1 q = reg_rdata;
  endtask : xfer

  task automatic mode(input logic on);
    @(posedge mclk);
    active_mode_set <= on;
    active_mode_clr <= !on;
    @(posedge mclk);
    {active_mode_set, active_mode_clr} <= 2'h0;
    #1;
  endtask : mode
endmodule : fault_protect_host

// ### fault_protect_interrupt_logic.sv
// fault supervision state machine, interrupt flags, enable mask and interrupt pin
`timescale 1ns/1ps
module fault_protect_interrupt_logic
  import fault_protect_pkg::*;
#(
  parameter int BLANK_CYCLES = SHORT_BLANK_CYCLES
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  input wire logic uvlo,
  // register port behind the serial interface
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // active mode control, writes of the active mode bit
  input wire logic active_mode_set,
  input wire logic active_mode_clr,
  // analog detectors
  input wire logic short_det,
  input wire logic clamp_reg,
  input wire logic overvolt_hi,
  input wire logic overvolt_lo,
  input wire logic thermal_hot,
  input wire logic thermal_warm,
  // light comparator outputs
  input wire logic main_office_level,
  input wire logic main_dark_level,
  input wire logic second_office_level,
  input wire logic second_dark_level,
  // gain selection inputs
  input wire logic ext_sinks_on,
  input wire logic headroom_upshift,
  // power control
  output logic pump_enable,
  output logic sinks_enable,
  output logic low_power,
  output logic standby,
  output logic short_sense_en,
  output logic gain_hold,
  // interrupt pin, open drain
  output logic irq_pin_n_out,
  output logic irq_pin_n_oe
);

  prot_state_t state_r;
  prot_state_t state_nxt;

  logic [4:0] flags;
  logic [4:0] mask_r;
  logic [4:0] mask_nxt;
  logic [4:0] flag_set;
  logic [4:0] flag_clr;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [3:0] light_prev_r;
  logic [3:0] light_now;
  logic light_valid_r;
  logic gain_hold_r;
  logic gain_hold_nxt;
  logic blank_start;
  logic blank_done;
  logic shorted;
  logic restart_ok;
  logic enter_ovp;
  logic enter_short;
  logic enter_thermal;
  logic in_run;
  logic wr_flags;
  logic wr_mask;
  logic rd_flags;
  logic rd_mask;

  // register decode
  assign wr_flags = reg_wr && (reg_addr == ADDR_FLAGS);
  assign wr_mask = reg_wr && (reg_addr == ADDR_MASK);
  assign rd_flags = reg_rd && (reg_addr == ADDR_FLAGS);
  assign rd_mask = reg_rd && (reg_addr == ADDR_MASK);

  // unmapped addresses read as zero; reads have no side effects
  assign rdata_nxt = rd_flags ? widen_flags(flags) : (rd_mask ? widen_flags(mask_r) : READ_ZERO);
  assign mask_nxt = uvlo ? MASK_RESET : (wr_mask ? reg_wdata[4:0] : mask_r);
  assign flag_clr = wr_flags ? reg_wdata[4:0] : 5'h00;

  // protection sequencing
  assign in_run = (state_r == ST_ACTIVE) || (state_r == ST_OVERVOLT);
  assign short_sense_en = in_run;
  assign shorted = short_sense_en && short_det;
  assign restart_ok = active_mode_set && !thermal_warm;
  assign enter_thermal = thermal_hot && (state_r != ST_THERMAL) && (state_r != ST_STANDBY);
  assign enter_short = shorted && !thermal_hot;
  assign enter_ovp = (state_r == ST_ACTIVE) && overvolt_hi && !shorted && !thermal_hot;
  assign blank_start = (state_nxt == ST_SOFTSTART) && (state_r != ST_SOFTSTART);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_STANDBY: begin
        if (restart_ok) begin
          state_nxt = ST_SOFTSTART;
        end
      end
      ST_SOFTSTART: begin
        // short sensing is blind here, a slow output would trip it otherwise
        if (blank_done) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (enter_short) begin
          state_nxt = ST_SHORTED;
        end else if (enter_ovp) begin
          state_nxt = ST_OVERVOLT;
        end
      end
      ST_OVERVOLT: begin
        if (enter_short) begin
          state_nxt = ST_SHORTED;
        end else if (overvolt_lo) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_SHORTED: begin
        if (active_mode_set) begin
          state_nxt = ST_SOFTSTART;
        end
      end
      ST_THERMAL: begin
        if (restart_ok) begin
          state_nxt = ST_SOFTSTART;
        end
      end
      default: begin
        state_nxt = ST_STANDBY;
      end
    endcase
    if (enter_thermal) begin
      state_nxt = ST_THERMAL;
    end else if (active_mode_clr) begin
      state_nxt = ST_STANDBY;
    end
    if (uvlo) begin
      state_nxt = ST_STANDBY;
    end
  end

  // power outputs follow state only
  assign pump_enable = (state_r == ST_SOFTSTART) || (state_r == ST_ACTIVE);
  assign sinks_enable = pump_enable || (state_r == ST_OVERVOLT);
  assign low_power = (state_r == ST_SHORTED) || (state_r == ST_THERMAL) || (state_r == ST_STANDBY);
  assign standby = (state_r == ST_STANDBY) || (state_r == ST_THERMAL);

  // light comparators: every change in either level of a sensor is an event
  assign light_now = {second_dark_level, second_office_level, main_dark_level, main_office_level};

  // clamp_reg is deliberately not a flag source
  always_comb begin
    flag_set = 5'h00;
    flag_set[BIT_MAIN_LIGHT] = light_valid_r && (light_now[1:0] != light_prev_r[1:0]);
    flag_set[BIT_SECOND_LIGHT] = light_valid_r && (light_now[3:2] != light_prev_r[3:2]);
    flag_set[BIT_OVERVOLTAGE] = (state_nxt == ST_OVERVOLT) && (state_r != ST_OVERVOLT);
    // still hot while in shutdown re-sets a cleared flag; cooling raises nothing
    flag_set[BIT_THERMAL] = enter_thermal || ((state_r == ST_THERMAL) && thermal_warm);
    flag_set[BIT_SHORT] = (state_nxt == ST_SHORTED) && (state_r != ST_SHORTED);
    if (uvlo) begin
      flag_set = 5'h00;
    end
  end

  // gain stays high while outside supplies feed sinks, dropped on disable or standby
  assign gain_hold_nxt = (!ext_sinks_on || standby || uvlo) ? 1'b0 : (gain_hold_r || headroom_upshift);
  assign gain_hold = gain_hold_r;

  // open drain pin pulled low while any enabled flag pends
  assign irq_pin_n_out = 1'b0;
  assign irq_pin_n_oe = |(flags & mask_r);
  assign reg_rdata = rdata_r;

  sticky_flags u_flags (
    .mclk(mclk),
    .nrst(nrst),
    .sync_clear(uvlo),
    .set_pulse(flag_set),
    .clear_mask(flag_clr),
    .flags(flags)
  );

  blank_timer #(
    .CYCLES(BLANK_CYCLES)
  ) u_blank (
    .mclk(mclk),
    .nrst(nrst),
    .start(blank_start),
    .abort(state_nxt != ST_SOFTSTART),
    .done(blank_done)
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_STANDBY;
      mask_r <= MASK_RESET;
      rdata_r <= READ_ZERO;
      light_prev_r <= 4'h0;
      light_valid_r <= 1'b0;
      gain_hold_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
      light_prev_r <= light_now;
      light_valid_r <= !uvlo;
      gain_hold_r <= gain_hold_nxt;
    end
  end

endmodule : fault_protect_interrupt_logic

// ### fault_protect_interrupt_logic_bench.sv
// self-checking bench for the fault protection and interrupt logic
`timescale 1ns/1ps
module fault_protect_interrupt_logic_bench;
  typedef struct packed {logic [3:0] lv; logic [7:0] fl;} row_t;
  // light levels in order: main office, main dark, second office, second dark
  localparam row_t ROWS [7] = '{'{4'h1, 8'h01}, '{4'h0, 8'h01}, '{4'h2, 8'h01}, '{4'h6, 8'h02},
    '{4'hE, 8'h02}, '{4'hC, 8'h01}, '{4'h0, 8'h02}};
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic uvlo = 1'b0;
  logic [7:0] det = 8'h00;
  logic [3:0] lite = 4'h0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic reg_wr, reg_rd, active_mode_set, active_mode_clr, irq_pin_n_out, irq_pin_n_oe, irq_n;
  logic pump_enable, sinks_enable, low_power, standby, short_sense_en, gain_hold;
  int fail_count = 0;
  int total_checks = 0;

  always #5 mclk = ~mclk;

  fault_protect_interrupt_logic #(.BLANK_CYCLES(20)) dut_u (.mclk, .nrst, .uvlo, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rdata, .active_mode_set, .active_mode_clr, .short_det(det[0]), .clamp_reg(det[1]),
    .overvolt_hi(det[2]), .overvolt_lo(det[3]), .thermal_hot(det[4]), .thermal_warm(det[5]),
    .main_office_level(lite[0]), .main_dark_level(lite[1]), .second_office_level(lite[2]),
    .second_dark_level(lite[3]), .ext_sinks_on(det[6]), .headroom_upshift(det[7]), .pump_enable, .sinks_enable,
    .low_power, .standby, .short_sense_en, .gain_hold, .irq_pin_n_out, .irq_pin_n_oe);
  fault_protect_host host_u (.mclk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .active_mode_set,
    .active_mode_clr, .irq_pin_n_out, .irq_pin_n_oe, .irq_n);

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.xfer(1'b1, a, d, v);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host_u.xfer(1'b0, a, 8'h00, v);
    chk(v, exp, $sformatf("register %h", a));
  endtask : rchk
  task automatic drive(input logic [7:0] d, input logic [3:0] l, input int n);
    @(posedge mclk);
    det <= d;
    lite <= l;
    repeat (n) @(posedge mclk);
    #1;
  endtask : drive
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #100us;
    fail_count++;
    print_verdict();
  end

  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    rchk(8'h02, 8'h00);
    rchk(8'h03, 8'h00);
    chk(8'({standby, low_power, pump_enable}), 8'h06, "reset power");
    wr(8'h03, 8'h20);
    rchk(8'h03, 8'h00);
    wr(8'h03, 8'hFF);
    rchk(8'h03, 8'h1F);
    wr(8'h07, 8'hFF);
    rchk(8'h07, 8'h00);
    foreach (ROWS[i]) begin
      drive(8'h00, ROWS[i].lv, 3);
      rchk(8'h02, ROWS[i].fl);
      chk(8'(irq_n), 8'h00, "pin pending");
      wr(8'h02, 8'h1F);
      chk(8'(irq_n), 8'h01, "pin cleared");
    end
    drive(8'h00, 4'h1, 3);
    wr(8'h02, 8'h00);
    rchk(8'h02, 8'h01);
    rchk(8'h02, 8'h01);
    wr(8'h03, 8'h1E);
    chk(8'(irq_n), 8'h01, "pin masked");
    wr(8'h03, 8'h1F);
    wr(8'h02, 8'h1F);
    // short held from the start: blanking must hide it for the whole soft start
    drive(8'h01, 4'h1, 0);
    host_u.mode(1'b1);
    chk(8'({pump_enable, short_sense_en}), 8'h02, "soft start");
    drive(8'h01, 4'h1, 18);
    chk(8'(short_sense_en), 8'h00, "blanked");
    drive(8'h01, 4'h1, 0);
    chk(8'(short_sense_en), 8'h01, "sensing");
    drive(8'h00, 4'h1, 1);
    rchk(8'h02, 8'h10);
    chk(8'({low_power, pump_enable}), 8'h02, "shorted");
    wr(8'h02, 8'h10);
    host_u.mode(1'b1);
    chk(8'({pump_enable, short_sense_en, low_power}), 8'h04, "restart");
    drive(8'h02, 4'h1, 22);
    drive(8'h04, 4'h1, 2);
    chk(8'({pump_enable, sinks_enable}), 8'h01, "overvoltage");
    rchk(8'h02, 8'h04);
    wr(8'h02, 8'h04);
    drive(8'h08, 4'h1, 2);
    chk(8'(pump_enable), 8'h01, "resume");
    rchk(8'h02, 8'h00);
    drive(8'h04, 4'h1, 2);
    rchk(8'h02, 8'h04);
    drive(8'hC4, 4'h1, 2);
    chk(8'(gain_hold), 8'h01, "gain held");
    drive(8'h04, 4'h1, 2);
    chk(8'(gain_hold), 8'h00, "gain freed");
    drive(8'h34, 4'h1, 2);
    chk(8'({standby, pump_enable}), 8'h02, "thermal");
    wr(8'h02, 8'h1F);
    rchk(8'h02, 8'h08);
    host_u.mode(1'b1);
    chk(8'(standby), 8'h01, "refused");
    drive(8'h00, 4'h1, 0);
    wr(8'h02, 8'h1F);
    rchk(8'h02, 8'h00);
    host_u.mode(1'b1);
    chk(8'(standby), 8'h00, "restarted");
    drive(8'h00, 4'h0, 3);
    rchk(8'h02, 8'h01);
    @(posedge mclk);
    uvlo <= 1'b1;
    @(posedge mclk);
    uvlo <= 1'b0;
    rchk(8'h02, 8'h00);
    rchk(8'h03, 8'h00);
    chk(8'(standby), 8'h01, "undervoltage");
    wr(8'h03, 8'h1F);
    drive(8'h00, 4'h4, 3);
    rchk(8'h02, 8'h02);
    wr(8'h03, 8'h00);
    chk(8'(irq_n), 8'h01, "pin all masked");
    wr(8'h03, 8'h1F);
    chk(8'(irq_n), 8'h00, "pin unmasked");
    @(posedge mclk);
    nrst <= 1'b0;
    @(posedge mclk);
    nrst <= 1'b1;
    rchk(8'h02, 8'h00);
    chk(8'(irq_n), 8'h01, "pin after reset");
    print_verdict();
  end
endmodule : fault_protect_interrupt_logic_bench

// ### fault_protect_pkg.sv
// constants, register map and state codes for the fault protection and interrupt logic
// Contract
// - output counts as shorted when detector reports below 55% input, if sensing enabled
// - short detector ignored during startup and restarts; re-enabled 4 ms after pump start
// - short fault enters low current state and sets the short flag
// - host restarts after short by writing active mode 1; full soft start reruns
// - output merely regulated at clamp level never sets any flag
// - above overvoltage threshold only the charge pump stops; sinks keep running; code ignores overvoltage in soft start, pump keeps running
// - pump resumes after output falls about 500 mV; cycle repeats on recurrence
// - overvoltage flag sets on every entry into overvoltage mode
// - over 150 C: shut down most functions, enter standby, set thermal flag; code sets no thermal flag when already in standby
// - after thermal shutdown host restarts via active mode, only once below 130 C
// - no interrupt when temperature falls back below recovery threshold
// - thermal flag cleared while still hot is set again
// - five flags at 0x02: main light, second light, overvoltage, thermal, short
// - main light flag sets on every office or dark comparator transition, either direction
// - second light flag works the same from the second sensor input
// - interrupt pin driven only by pending flags enabled in mask at 0x03
// - write 1 clears a flag; device reset clears it too
// - reading a flag or writing 0 leaves it unchanged
// - gain may stay high while external sinks are on, until off or standby
// - reset and undervoltage lockout return all registers to defaults
package fault_protect_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int SHORT_BLANK_TIME_US = 4000;
  localparam int SHORT_BLANK_CYCLES = (SHORT_BLANK_TIME_US * 1000) / CLK_PERIOD_NS;

  localparam logic [7:0] ADDR_FLAGS = 8'h02;
  localparam logic [7:0] ADDR_MASK = 8'h03;

  localparam int NUM_FLAGS = 5;
  localparam int BIT_MAIN_LIGHT = 0;
  localparam int BIT_SECOND_LIGHT = 1;
  localparam int BIT_OVERVOLTAGE = 2;
  localparam int BIT_THERMAL = 3;
  localparam int BIT_SHORT = 4;

  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam logic [4:0] MASK_RESET = 5'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_SOFTSTART = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_OVERVOLT = 3'b011,
    ST_SHORTED = 3'b100,
    ST_THERMAL = 3'b101
  } prot_state_t;

  function automatic logic [7:0] widen_flags(input logic [4:0] v);
    widen_flags = {3'b000, v};
  endfunction : widen_flags

endpackage : fault_protect_pkg

// ### fault_protect_properties.sv
// port-level assertions for the fault protection and interrupt logic
`timescale 1ns/1ps
module fault_protect_properties
  import fault_protect_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  input wire logic uvlo,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // mode writes and detectors
  input wire logic active_mode_set,
  input wire logic active_mode_clr,
  input wire logic short_det,
  input wire logic overvolt_hi,
  input wire logic thermal_hot,
  input wire logic thermal_warm,
  // power control and pin
  input wire logic pump_enable,
  input wire logic sinks_enable,
  input wire logic low_power,
  input wire logic standby,
  input wire logic short_sense_en,
  input wire logic irq_pin_n_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // events that override every fault reaction are kept out of the antecedents
  wire calm = !uvlo && !thermal_hot && !active_mode_clr;

  chk_mask_quiets_pin: assert property (
    reg_wr && reg_addr == ADDR_MASK && reg_wdata[4:0] == 5'h00 |=> !irq_pin_n_oe)
    else $error("pin pulled with every source masked");
  chk_reserved_bits_zero: assert property (
    reg_rd |=> reg_rdata[7:5] == 3'h0) else $error("unused flag bits read nonzero");
  chk_unmapped_read_zero: assert property (
    reg_rd && reg_addr != ADDR_FLAGS && reg_addr != ADDR_MASK |=> reg_rdata == READ_ZERO)
    else $error("unmapped read returned data");
  chk_ov_pump_only: assert property (
    overvolt_hi && pump_enable && short_sense_en && !short_det && calm |=> !pump_enable && sinks_enable)
    else $error("overvoltage did not stop the pump alone");
  chk_short_low_power: assert property (
    short_det && short_sense_en && pump_enable && !overvolt_hi && calm |=> low_power && !pump_enable)
    else $error("short did not enter low power");
  chk_blank_after_start: assert property (
    $rose(pump_enable) && !short_sense_en |-> !short_sense_en [*8])
    else $error("short sensing during soft start");
  chk_thermal_standby: assert property (
    thermal_hot && !standby |=> standby && !pump_enable) else $error("no standby when hot");
  chk_thermal_restart_hold: assert property (
    standby && thermal_warm && active_mode_set |=> standby) else $error("restart accepted while warm");
endmodule : fault_protect_properties

bind fault_protect_interrupt_logic fault_protect_properties chk_u (.mclk, .nrst, .uvlo, .reg_addr, .reg_wr,
  .reg_wdata, .reg_rd, .reg_rdata, .active_mode_set, .active_mode_clr, .short_det, .overvolt_hi, .thermal_hot,
  .thermal_warm, .pump_enable, .sinks_enable, .low_power, .standby, .short_sense_en, .irq_pin_n_oe);

// ### sticky_flags.sv
// write-one-to-clear sticky flag bank, set wins over clear
`timescale 1ns/1ps
module sticky_flags
  import fault_protect_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  input wire logic sync_clear,
  // flag events and clears
  input wire logic [4:0] set_pulse,
  input wire logic [4:0] clear_mask,
  // state
  output logic [4:0] flags
);

  logic [4:0] flags_r;
  logic [4:0] flags_nxt;

  // a set in the clear cycle survives
  assign flags_nxt = sync_clear ? FLAGS_RESET : ((flags_r & ~clear_mask) | set_pulse);
  assign flags = flags_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flags_r <= FLAGS_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

endmodule : sticky_flags
